// >>> tb/aosr_chk_sva.sv
// Checker for the output and status register bank
`timescale 1ns/100ps
module aosr_chk #(
    parameter [7:0] IDENT_VALUE = 8'h00
) (
    input wire       clk,
    input wire       nrst,
    input wire       rd_strobe,
    input wire [7:0] rd_addr,
    input wire [7:0] rd_data,
    input wire       rd_busy,
    input wire       sample_valid,
    input wire       orient_valid,
    input wire       tap_event,
    input wire       motion_pin,
    input wire       new_sample_flag_int_en,
    input wire       selftest_set,
    input wire       selftest_trigger,
    input wire       int_out
);
    reg  [2:0] quiet_q;
    wire [2:0] quiet_d;
    wire       st_rd = rd_strobe && rd_addr == 8'h0c && !selftest_set;
    // Events still in flight may reassert after a release, so wait them out
    assign quiet_d = (sample_valid || orient_valid || tap_event || motion_pin)
        ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
    always @(posedge clk) quiet_q <= nrst ? quiet_d : 3'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_resp_idle: assert property (
        st_rd && !selftest_trigger |=> rd_data == 8'h55)
        else $error("idle response wrong");
    a_resp_active: assert property (
        st_rd && selftest_trigger |=> rd_data == 8'haa)
        else $error("active response wrong");
    a_resp_restore: assert property (
        st_rd && selftest_trigger ##2 st_rd |=> rd_data == 8'h55)
        else $error("response not restored");
    a_trig_set: assert property (
        selftest_set |=> selftest_trigger)
        else $error("trigger not set");
    a_trig_clear: assert property (
        st_rd |=> !selftest_trigger)
        else $error("trigger not cleared");
    a_ident_fixed: assert property (
        rd_strobe && rd_addr == 8'h0f |=> rd_data == IDENT_VALUE)
        else $error("identity wrong");
    a_release_int: assert property (
        rd_strobe && rd_addr == 8'h1a && quiet_q == 3'h7 |=> !int_out)
        else $error("interrupt not released");
    a_ready_int: assert property (
        sample_valid && new_sample_flag_int_en && !rd_busy ##1
        (!rd_busy && !rd_strobe && new_sample_flag_int_en) [*2] |-> ##[1:4] int_out)
        else $error("ready interrupt missing");
    a_orient_onehot: assert property (
        rd_strobe && (rd_addr == 8'h10 || rd_addr == 8'h11)
        |=> rd_data[7:6] == 2'h0 && $onehot(rd_data[5:0]))
        else $error("orientation not one-hot");
    a_tap_code: assert property (
        rd_strobe && rd_addr == 8'h16 |=> rd_data[3:2] != 2'h3 &&
        rd_data[7:5] == 3'h0)
        else $error("function source code illegal");
endmodule // aosr_chk
bind aosr_regs aosr_chk #(.IDENT_VALUE(IDENT_VALUE)) u_chk (
    .clk, .nrst, .rd_strobe, .rd_addr, .rd_data, .rd_busy, .sample_valid,
    .orient_valid, .tap_event, .motion_pin, .new_sample_flag_int_en, .selftest_set,
    .selftest_trigger, .int_out);

// >>> tb/aosr_host_model.sv
// Host side model issuing register reads
`timescale 1ns/100ps
module aosr_host_model (
    input  wire       clk,
    output reg        rd_strobe,
    output reg  [7:0] rd_addr,
    output reg        rd_busy,
    input  wire [7:0] rd_data
);
    initial begin
        rd_strobe = 1'b0;
        rd_addr   = 8'hff;
        rd_busy   = 1'b0;
    end
    // Busy may stay up across reads so a burst sees one sample
    task rd(input [7:0] a, input keep, output [7:0] d);
        begin
            @(posedge clk);
            #1;
            rd_strobe = 1'b1;
            rd_addr   = a;
            rd_busy   = 1'b1;
            @(posedge clk);
            #1;
            rd_strobe = 1'b0;
            // Idle address flips so a stale match cannot hide
            rd_addr   = ~a;
            rd_busy   = keep;
            d         = rd_data;
        end
    endtask
endmodule // aosr_host_model

// >>> tb/test_accel_output_status_regs.sv
// Self-checking bench for the output and status register bank
`timescale 1ns/100ps
module test_accel_output_status_regs;
    localparam [7:0] IDENT = 8'h3c; // Arbitrary identity value
    reg         clk = 1'b0, nrst = 1'b0, res_12bit = 1'b1, int_en = 1'b1;
    reg         sample_valid = 1'b0, orient_valid = 1'b0, tap_event = 1'b0;
    reg         tap_double = 1'b0, selftest_set = 1'b0;
    reg         motion_pin = 1'b0, motion_unlatched = 1'b0;
    reg  [11:0] sample_x = 12'h000, sample_y = 12'h000, sample_z = 12'h000;
    reg  [5:0]  orient_new = 6'h00, tap_dir = 6'h00;
    reg  [7:0]  d;
    wire        rd_strobe, rd_busy, selftest_trigger, int_out;
    wire [7:0]  rd_addr, rd_data;
    integer     miscompares = 0, comparisons = 0, i;
    aosr_regs #(.IDENT_VALUE(IDENT)) uut (
        .clk, .nrst, .rd_strobe, .rd_addr, .rd_busy, .rd_data, .res_12bit,
        .sample_valid, .sample_x, .sample_y, .sample_z, .orient_valid,
        .orient_new, .tap_event, .tap_double, .tap_dir, .motion_pin,
        .motion_unlatched, .new_sample_flag_int_en(int_en), .tap_int_en(int_en),
        .motion_int_en(int_en), .orient_int_en(int_en), .selftest_set,
        .selftest_trigger, .int_out);
    aosr_host_model host (.clk, .rd_strobe, .rd_addr, .rd_busy, .rd_data);
    initial forever #2.5 clk = ~clk;
    task chk(input [63:0] nm, input [7:0] seen, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task rchk(input [7:0] a, input [7:0] exp);
        begin
            host.rd(a, 1'b0, d);
            chk("rd_data", d, exp);
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task samp(input [35:0] v);
        begin
            {sample_x, sample_y, sample_z} = v;
            sample_valid = 1'b1;
            cyc(1);
            sample_valid = 1'b0;
            cyc(4);
        end
    endtask
    task t_basic;
        begin
            rchk(8'h10, 8'h20);
            rchk(8'h11, 8'h20);
            rchk(8'h0c, 8'h55);
            rchk(8'h0f, IDENT);
            selftest_set = 1'b1;
            cyc(1);
            selftest_set = 1'b0;
            chk("trigger", {7'h00, selftest_trigger}, 8'h01);
            rchk(8'h0c, 8'haa);
            chk("trigger", {7'h00, selftest_trigger}, 8'h00);
            rchk(8'h0c, 8'h55);
            $display("test basic done");
        end
    endtask
    task t_data;
        begin
            // Masked first, so the summary must follow the enable
            int_en = 1'b0;
            samp({12'h801, 12'h7ff, 12'hfff});
            chk("int_out", {7'h00, int_out}, 8'h00);
            int_en = 1'b1;
            cyc(2);
            chk("int_out", {7'h00, int_out}, 8'h01);
            rchk(8'h16, 8'h10);
            rchk(8'h07, 8'h80);
            rchk(8'h06, 8'h10);
            rchk(8'h09, 8'h7f);
            rchk(8'h08, 8'hf0);
            rchk(8'h0b, 8'hff);
            rchk(8'h16, 8'h00);
            res_12bit = 1'b0;
            samp({12'h80f, 12'h000, 12'h011});
            rchk(8'h1a, 8'h00);
            chk("int_out", {7'h00, int_out}, 8'h00);
            rchk(8'h16, 8'h00);
            rchk(8'h07, 8'h80);
            rchk(8'h06, 8'h00);
            $display("test data done");
        end
    endtask
    task t_burst;
        begin
            res_12bit = 1'b1;
            host.rd(8'h0b, 1'b1, d);
            chk("rd_data", d, 8'h01);
            samp({12'h123, 12'h456, 12'h789});
            host.rd(8'h0a, 1'b0, d);
            chk("rd_data", d, 8'h00);
            cyc(4);
            rchk(8'h0b, 8'h78);
            rchk(8'h0a, 8'h90);
            $display("test burst done");
        end
    endtask
    task t_tap;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                tap_dir = 6'h01 << i;
                tap_double = i[0];
                tap_event = 1'b1;
                cyc(1);
                tap_event = 1'b0;
                cyc(4);
                rchk(8'h15, {2'h0, tap_dir});
                rchk(8'h16, i[0] ? 8'h08 : 8'h04);
                chk("int_out", {7'h00, int_out}, 8'h01);
                rchk(8'h1a, 8'h00);
                rchk(8'h15, 8'h00);
                rchk(8'h16, 8'h00);
                chk("int_out", {7'h00, int_out}, 8'h00);
            end
            $display("test tap done");
        end
    endtask
    task t_motion;
        begin
            // Pin crosses the three-flop filter, so give it time to settle
            motion_pin = 1'b1;
            cyc(8);
            motion_pin = 1'b0;
            cyc(8);
            rchk(8'h16, 8'h02);
            rchk(8'h18, 8'h10);
            rchk(8'h1a, 8'h00);
            rchk(8'h18, 8'h00);
            rchk(8'h16, 8'h00);
            // Unlatched view drops with the pin although the latch is set
            motion_unlatched = 1'b1;
            motion_pin = 1'b1;
            cyc(8);
            rchk(8'h16, 8'h02);
            motion_pin = 1'b0;
            cyc(8);
            rchk(8'h16, 8'h00);
            motion_unlatched = 1'b0;
            rchk(8'h1a, 8'h00);
            $display("test motion done");
        end
    endtask
    task t_orient;
        begin
            for (i = 0; i < 2; i = i + 1) begin
                orient_new = 6'h01;
                orient_valid = 1'b1;
                cyc(1);
                orient_valid = 1'b0;
                cyc(4);
                rchk(8'h10, 8'h01);
                if (i == 0)
                    rchk(8'h11, 8'h20);
                rchk(8'h16, i ? 8'h00 : 8'h01);
                rchk(8'h1a, 8'h00);
            end
            // A mid-run reset must bring both positions back
            nrst = 1'b0;
            cyc(2);
            nrst = 1'b1;
            rchk(8'h10, 8'h20);
            rchk(8'h11, 8'h20);
            $display("test orient done");
        end
    endtask
    task wrap_up;
        begin
            $display("comparisons %0d miscompares %0d", comparisons,
                     miscompares);
            if (miscompares == 0 && comparisons > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_basic;
        t_data;
        t_burst;
        t_tap;
        t_motion;
        t_orient;
        wrap_up;
    end
endmodule // test_accel_output_status_regs

// >>> verilog/aosr_axis.v
// One axis sample holder with coherent high/low bytes
`timescale 1ns/100ps
module aosr_axis (
    input  wire        clk,
    input  wire        nrst,
    input  wire        load,
    input  wire [11:0] sample,
    output wire [7:0]  high_byte,
    output wire [7:0]  low_byte
);
    reg [11:0] val_q;
    // Loads are gated by the caller so both bytes share one sample
    always @(posedge clk) begin
        if (!nrst) begin
            val_q <= 12'h000;
        end else if (load) begin
            val_q <= sample;
        end
    end
    assign high_byte = val_q[11:4];
    assign low_byte  = {val_q[3:0], 4'h0};
endmodule // aosr_axis

// >>> verilog/aosr_consts.vh
// Register map constants and behaviour list for the output/status bank
// Behaviour
// - Axis high bytes carry sample bits 11..4, bit 7 most significant.
// - Axis low bytes carry sample bits 3..0 in bits 7..4; low nibble reads zero.
// - Self-test response reads 0x55 while the trigger bit is clear.
// - Setting the self-test trigger loads the response register with 0xAA.
// - Reading the response while it holds 0xAA restores it to 0x55.
// - Reading the response register also clears the self-test trigger bit.
// - Supplier identity is a fixed read-only byte, same on every read.
// - Orientation registers update at their rate, frozen during a host read.
// - Orientation bits are one-hot: X-,X+,Y-,Y+,Z-,Z+ in bits 5..0; 7..6 zero.
// - After reset both orientation registers hold X-negative, bit 5 only.
// - Tap source flags tap axis and direction in the same one-hot layout.
// - Source registers update on events and hold until release is read.
// - Motion flag may follow the motion condition unlatched when selected.
// - Function source: ready bit 4, tap type 3..2, motion 1, orientation 0.
// - Reading the release register clears the whole function source register; in unlatched mode the motion bit keeps following the live condition.
// - Ready flag sets on new sample, clears on data read or release read.
// - Tap type encodes 00 none, 01 single, 10 double; 11 never produced.
// - Orientation-change flag is one when orientation changed since release.
// - Summary interrupt bit is OR of enabled functions, cleared on release.
// - Release read clears both sources, summary bit and interrupt output; the unlatched motion bit is not cleared.
// - Acceleration values are two's complement, 12-bit or 8-bit range.
// - Acceleration outputs refresh per sample, never during a host read.
`ifndef AOSR_CONSTS_VH
`define AOSR_CONSTS_VH
`define AOSR_ADDR_XL      8'h06
`define AOSR_ADDR_XH      8'h07
`define AOSR_ADDR_YL      8'h08
`define AOSR_ADDR_YH      8'h09
`define AOSR_ADDR_ZL      8'h0a
`define AOSR_ADDR_ZH      8'h0b
`define AOSR_ADDR_STRESP  8'h0c
`define AOSR_ADDR_IDENT   8'h0f
`define AOSR_ADDR_ORCUR   8'h10
`define AOSR_ADDR_ORPRE   8'h11
`define AOSR_ADDR_TAPSRC  8'h15
`define AOSR_ADDR_FUNSRC  8'h16
`define AOSR_ADDR_SUMMARY 8'h18
`define AOSR_ADDR_RELEASE 8'h1a
`define AOSR_ST_IDLE      8'h55
`define AOSR_ST_ACTIVE    8'haa
`define AOSR_ORIENT_RST   6'h20
`define AOSR_IDENT_DEF    8'h5a
`define AOSR_SUM_INT_BIT  4
`define AOSR_FUN_RDY_BIT  4
`define AOSR_TAP_NONE     2'h0
`define AOSR_TAP_SINGLE   2'h1
`define AOSR_TAP_DOUBLE   2'h2
`endif

// >>> verilog/aosr_regs.v
// Acceleration output, orientation and interrupt source register bank
`timescale 1ns/100ps
`include "aosr_consts.vh"
module aosr_regs #(
    parameter [7:0] IDENT_VALUE = `AOSR_IDENT_DEF
) (
    input  wire        clk,
    input  wire        nrst,
    input  wire        rd_strobe,
    input  wire [7:0]  rd_addr,
    input  wire        rd_busy,
    output reg  [7:0]  rd_data,
    input  wire        res_12bit,
    input  wire        sample_valid,
    input  wire [11:0] sample_x,
    input  wire [11:0] sample_y,
    input  wire [11:0] sample_z,
    input  wire        orient_valid,
    input  wire [5:0]  orient_new,
    input  wire        tap_event,
    input  wire        tap_double,
    input  wire [5:0]  tap_dir,
    input  wire        motion_pin,
    input  wire        motion_unlatched,
    input  wire        new_sample_flag_int_en,
    input  wire        tap_int_en,
    input  wire        motion_int_en,
    input  wire        orient_int_en,
    input  wire        selftest_set,
    output reg         selftest_trigger,
    output reg         int_out
);
    reg  [11:0] pend_x_q;
    reg  [11:0] pend_y_q;
    reg  [11:0] pend_z_q;
    reg         pend_q;
    reg  [5:0]  or_cur_q;
    reg  [5:0]  or_pre_q;
    reg  [5:0]  or_pend_q;
    reg         or_pend_v_q;
    reg  [7:0]  st_resp_q;
    reg  [5:0]  tap_dir_q;
    reg  [1:0]  tap_type_q;
    reg         motion_q;
    reg         orchg_q;
    reg         new_sample_flag_q;
    reg         sum_q;
    wire        motion_sync;
    wire [7:0]  xh;
    wire [7:0]  xl;
    wire [7:0]  yh;
    wire [7:0]  yl;
    wire [7:0]  zh;
    wire [7:0]  zl;
    wire        acc_rd;
    wire        rel_rd;
    wire        st_rd;
    wire        acc_load;
    wire        or_load;
    wire        motion_bit;
    wire [11:0] in_x;
    wire [11:0] in_y;
    wire [11:0] in_z;
    wire [7:0]  fun_src;
    wire        any_int;

    // Motion condition arrives from the analog front end
    aosr_sync #(.W(1)) u_msync (
        .clk  (clk),
        .nrst (nrst),
        .din  (motion_pin),
        .dout (motion_sync)
    );

    // 8-bit mode keeps only the top byte; low nibble forced zero
    assign in_x = res_12bit ? sample_x : {sample_x[11:4], 4'h0};
    assign in_y = res_12bit ? sample_y : {sample_y[11:4], 4'h0};
    assign in_z = res_12bit ? sample_z : {sample_z[11:4], 4'h0};

    // Holding off while the host reads keeps both bytes from one sample
    assign acc_load = pend_q && !rd_busy;
    assign or_load  = or_pend_v_q && !rd_busy;

    aosr_axis u_ax (
        .clk       (clk),
        .nrst      (nrst),
        .load      (acc_load),
        .sample    (pend_x_q),
        .high_byte (xh),
        .low_byte  (xl)
    );
    aosr_axis u_ay (
        .clk       (clk),
        .nrst      (nrst),
        .load      (acc_load),
        .sample    (pend_y_q),
        .high_byte (yh),
        .low_byte  (yl)
    );
    aosr_axis u_az (
        .clk       (clk),
        .nrst      (nrst),
        .load      (acc_load),
        .sample    (pend_z_q),
        .high_byte (zh),
        .low_byte  (zl)
    );

    assign acc_rd = rd_strobe && (rd_addr >= `AOSR_ADDR_XL) &&
                    (rd_addr <= `AOSR_ADDR_ZH);
    assign rel_rd = rd_strobe && (rd_addr == `AOSR_ADDR_RELEASE);
    assign st_rd  = rd_strobe && (rd_addr == `AOSR_ADDR_STRESP);

    // Unlatched mode shows the live condition instead of the latch
    assign motion_bit = motion_unlatched ? motion_sync : motion_q;
    assign fun_src = {3'b000, new_sample_flag_q, tap_type_q, motion_bit, orchg_q};
    assign any_int = (new_sample_flag_q && new_sample_flag_int_en) ||
                     ((tap_type_q != `AOSR_TAP_NONE) && tap_int_en) ||
                     (motion_bit && motion_int_en) ||
                     (orchg_q && orient_int_en);

    // Sample staging: newest sample waits until the bus goes quiet
    always @(posedge clk) begin
        if (!nrst) begin
            pend_x_q <= 12'h000;
            pend_y_q <= 12'h000;
            pend_z_q <= 12'h000;
            pend_q   <= 1'b0;
        end else begin
            if (sample_valid) begin
                pend_x_q <= in_x;
                pend_y_q <= in_y;
                pend_z_q <= in_z;
                pend_q   <= 1'b1;
            end else if (acc_load) begin
                pend_q   <= 1'b0;
            end
        end
    end

    // Orientation staging and update
    always @(posedge clk) begin
        if (!nrst) begin
            or_cur_q    <= `AOSR_ORIENT_RST;
            or_pre_q    <= `AOSR_ORIENT_RST;
            or_pend_q   <= `AOSR_ORIENT_RST;
            or_pend_v_q <= 1'b0;
        end else begin
            if (orient_valid) begin
                or_pend_q   <= orient_new;
                or_pend_v_q <= 1'b1;
            end else if (or_load) begin
                or_pend_v_q <= 1'b0;
            end
            if (or_load && (or_pend_q != or_cur_q)) begin
                or_pre_q <= or_cur_q;
                or_cur_q <= or_pend_q;
            end
        end
    end

    // Self-test response; a new trigger set wins over a read clear
    always @(posedge clk) begin
        if (!nrst) begin
            st_resp_q        <= `AOSR_ST_IDLE;
            selftest_trigger <= 1'b0;
        end else if (selftest_set) begin
            st_resp_q        <= `AOSR_ST_ACTIVE;
            selftest_trigger <= 1'b1;
        end else if (st_rd) begin
            st_resp_q        <= `AOSR_ST_IDLE;
            selftest_trigger <= 1'b0;
        end
    end

    // Latched sources: events set, release clears; set wins the same cycle
    always @(posedge clk) begin
        if (!nrst) begin
            tap_dir_q  <= 6'h00;
            tap_type_q <= `AOSR_TAP_NONE;
            motion_q   <= 1'b0;
            orchg_q    <= 1'b0;
            new_sample_flag_q     <= 1'b0;
            sum_q      <= 1'b0;
            int_out    <= 1'b0;
        end else begin
            if (tap_event) begin
                tap_dir_q  <= tap_dir;
                tap_type_q <= tap_double ? `AOSR_TAP_DOUBLE
                                         : `AOSR_TAP_SINGLE;
            end else if (rel_rd) begin
                tap_dir_q  <= 6'h00;
                tap_type_q <= `AOSR_TAP_NONE;
            end
            if (motion_sync) begin
                motion_q <= 1'b1;
            end else if (rel_rd) begin
                motion_q <= 1'b0;
            end
            if (or_load && (or_pend_q != or_cur_q)) begin
                orchg_q <= 1'b1;
            end else if (rel_rd) begin
                orchg_q <= 1'b0;
            end
            if (acc_load) begin
                new_sample_flag_q <= 1'b1;
            end else if (acc_rd || rel_rd) begin
                new_sample_flag_q <= 1'b0;
            end
            if (rel_rd) begin
                sum_q   <= 1'b0;
                int_out <= 1'b0;
            end else begin
                sum_q   <= any_int;
                int_out <= any_int;
            end
        end
    end

    // Read mux; unmapped addresses return zero
    always @(posedge clk) begin
        if (!nrst) begin
            rd_data <= 8'h00;
        end else if (rd_strobe) begin
            case (rd_addr)
                `AOSR_ADDR_XL:      rd_data <= xl;
                `AOSR_ADDR_XH:      rd_data <= xh;
                `AOSR_ADDR_YL:      rd_data <= yl;
                `AOSR_ADDR_YH:      rd_data <= yh;
                `AOSR_ADDR_ZL:      rd_data <= zl;
                `AOSR_ADDR_ZH:      rd_data <= zh;
                `AOSR_ADDR_STRESP:  rd_data <= st_resp_q;
                `AOSR_ADDR_IDENT:   rd_data <= IDENT_VALUE;
                `AOSR_ADDR_ORCUR:   rd_data <= {2'b00, or_cur_q};
                `AOSR_ADDR_ORPRE:   rd_data <= {2'b00, or_pre_q};
                `AOSR_ADDR_TAPSRC:  rd_data <= {2'b00, tap_dir_q};
                `AOSR_ADDR_FUNSRC:  rd_data <= fun_src;
                `AOSR_ADDR_SUMMARY: rd_data <= {3'b000, sum_q, 4'h0};
                default:            rd_data <= 8'h00;
            endcase
        end
    end
endmodule // aosr_regs

// >>> verilog/aosr_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module aosr_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         nrst,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    wire [W-1:0] dout_d;
    genvar i;
    always @(posedge clk) begin
        if (!nrst) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // A change counts only once stages two and three agree
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            assign dout_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : dout[i];
        end
    endgenerate
    // One process owns the whole output so no bit has two drivers
    always @(posedge clk) begin
        if (!nrst) begin
            dout <= {W{1'b0}};
        end else begin
            dout <= dout_d;
        end
    end
endmodule // aosr_sync
